//--- hw/storage_access.v
// byte storage access controller with self-timed programming
`timescale 1ns/1ns
`include "storage_defines.vh"

// What this block does
// RULE_01: sixty-four separate bytes, each read and written alone
// RULE_02: address, data, control live in io space
// RULE_03: read stalls the processor four cycles
// RULE_04: program trigger stalls the processor two cycles
// RULE_05: mode zero with arm does erase plus write
// RULE_06: busy bit stays set until programming ends
// RULE_07: no other storage operation while busy
// RULE_08: mode one erases only the addressed byte
// RULE_09: mode two writes only, no erase
// RULE_10: software erases before write-only, else undefined
// RULE_11: programming timed from calibrated oscillator tick
// RULE_12: reset does not abort running programming
// RULE_13: poll busy, then mode, address, data, arm, trigger
// RULE_14: read strobe loads addressed byte into data
// RULE_15: bit set and clear touch only that bit
// RULE_16: address bits seven and six read zero
// RULE_17: arm self-clears after four cycles, gates trigger
// RULE_18: mode writes ignored while busy, reset clears mode; a reset while busy leaves mode unchanged
// RULE_19: atomic 3.4 ms, split 1.8 ms, mode three reserved
// RULE_20: linear address 0 to 63, frozen while busy
// RULE_21: reserved mode trigger starts nothing
module storage_access #(
  parameter OSC_KHZ = 9600,
  parameter [31:0] ATOMIC_TICKS = `T_ATOMIC_US * OSC_KHZ / 1000,
  parameter [31:0] SPLIT_TICKS = `T_SPLIT_US * OSC_KHZ / 1000
) (
  // clock, reset, enable
  input wire clock_in,
  input wire nrst_in,
  input wire clk_en_in,
  // calibrated oscillator level, counted once per period when it stays high for two clock_in cycles
  input wire osc_tick_in,
  // io register port
  input wire [5:0] io_addr_in,
  input wire io_wr_in,
  input wire io_rd_in,
  input wire [7:0] io_wdata_in,
  input wire io_bit_op_in,
  input wire [2:0] io_bit_sel_in,
  input wire io_bit_val_in,
  output reg [7:0] io_rdata_out,
  // cpu stall and status
  output reg cpu_stall_out,
  output reg busy_out
);

  reg [7:0] mem_q [0:`DEPTH-1];
  reg [5:0] adr_q;
  reg [7:0] data_q;
  reg [1:0] mode_q;
  reg rdyie_q;
  reg arm_q;
  reg [2:0] arm_cnt_q;
  reg busy_q;
  reg [1:0] op_q;
  reg [31:0] prog_cnt_q;
  reg [2:0] stall_q;
  reg t1_q, t2_q, t3_q;
  reg lvl_q;
  reg [5:0] op_adr_q;
  reg [7:0] op_data_q;
  reg tick_q;

  wire [7:0] ctrl_rd;
  reg [7:0] wr_val;
  wire wr_ctrl;
  wire wr_data;
  wire wr_adr;
  wire trig;
  wire rd_go;
  wire [31:0] ticks;

  assign ctrl_rd = {2'b00, mode_q, rdyie_q, arm_q, busy_q, 1'b0};

  ////////////////////////////////////////////////////////////////
  // io decode; a bit op rewrites only the selected bit so that no
  // other bit sees a write
  always @* begin
    case (io_addr_in)
      `IO_CTRL_ADDR: wr_val = ctrl_rd;
      `IO_DATA_ADDR: wr_val = data_q;
      `IO_ADR_ADDR: wr_val = {2'b00, adr_q};
      default: wr_val = `BYTE_ZERO;
    endcase
    if (io_bit_op_in) begin
      wr_val[io_bit_sel_in] = io_bit_val_in; // RULE_15
    end else begin
      wr_val = io_wdata_in;
    end
  end

  assign wr_ctrl = clk_en_in && io_wr_in && (io_addr_in == `IO_CTRL_ADDR); // RULE_02
  assign wr_data = clk_en_in && io_wr_in && (io_addr_in == `IO_DATA_ADDR);
  assign wr_adr = clk_en_in && io_wr_in && (io_addr_in == `IO_ADR_ADDR);
  // a trigger only counts when it writes a one into the busy bit, by a byte
  // write or a bit op on that bit, so bit ops on other bits never fire it
  assign trig = wr_ctrl && wr_val[`CTL_TRIG] && arm_q && !busy_q
    && (!io_bit_op_in || io_bit_sel_in == `CTL_TRIG) && mode_q != `MODE_RSVD; // RULE_17 RULE_21
  assign rd_go = wr_ctrl && wr_val[`CTL_READ] && !busy_q; // RULE_07
  assign ticks = (mode_q == `MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS; // RULE_19

  ////////////////////////////////////////////////////////////////
  // oscillator tick synchroniser: 3 flops; the level moves only once
  // stages 2 and 3 agree, so a metastable first stage never counts
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      t3_q <= 1'b0;
      lvl_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (clk_en_in) begin
      t1_q <= osc_tick_in;
      t2_q <= t1_q;
      t3_q <= t2_q;
      if (t2_q == t3_q) begin
        lvl_q <= t3_q;
      end
      tick_q <= t2_q & t3_q & ~lvl_q; // RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////
  // programming engine; never reset so a running operation finishes
  // and the array keeps its contents across reset
  always @(posedge clock_in) begin
    if (clk_en_in) begin
      if (trig) begin
        busy_q <= 1'b1; // RULE_06
        op_q <= mode_q;
        // address and data are latched: a reset during programming clears the
        // address and data registers but must not retarget the byte
        op_adr_q <= adr_q; // RULE_12
        op_data_q <= data_q;
        prog_cnt_q <= ticks;
      end else if (busy_q) begin
        // counting down to zero spends the full number of ticks
        if (prog_cnt_q == 32'h0) begin
          busy_q <= 1'b0; // RULE_06 RULE_12
          case (op_q)
            `MODE_ATOMIC: mem_q[op_adr_q] <= op_data_q; // RULE_05
            `MODE_ERASE: mem_q[op_adr_q] <= `ERASED_BYTE; // RULE_08
            `MODE_WRITE: mem_q[op_adr_q] <= mem_q[op_adr_q] & op_data_q; // RULE_09 RULE_10
            default: mem_q[op_adr_q] <= mem_q[op_adr_q];
          endcase
        end else if (tick_q) begin
          prog_cnt_q <= prog_cnt_q - 32'd1; // RULE_11
        end
      end else begin
        busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // control, address and data registers
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adr_q <= 6'h00;
      data_q <= `BYTE_ZERO;
      rdyie_q <= 1'b0;
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else if (clk_en_in) begin
      if (wr_adr && !busy_q) begin
        adr_q <= wr_val[5:0]; // RULE_20 RULE_01
      end
      if (rd_go) begin
        data_q <= mem_q[adr_q]; // RULE_14
      end else if (wr_data) begin
        data_q <= wr_val;
      end
      if (wr_ctrl) begin
        rdyie_q <= wr_val[`CTL_RDYIE];
      end
      // arm window counts down and drops the arm bit itself
      if (wr_ctrl && wr_val[`CTL_ARM] && !arm_q) begin
        arm_q <= 1'b1;
        arm_cnt_q <= `ARM_CYCLES; // RULE_17
      end else if (trig || (arm_q && arm_cnt_q == 3'h1)) begin
        arm_q <= 1'b0; // RULE_17
        arm_cnt_q <= 3'h0;
      end else if (arm_q) begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // mode field; reset clears it only when no programming runs, so it
  // cannot sit in the async reset branch and is cleared on the clock
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      if (!busy_q) begin
        mode_q <= `MODE_ATOMIC; // RULE_18
      end
    end else if (clk_en_in) begin
      if (wr_ctrl && !busy_q) begin
        mode_q <= wr_val[`CTL_MODE_HI:`CTL_MODE_LO]; // RULE_18
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // cpu stall counter and registered outputs
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stall_q <= 3'h0;
      cpu_stall_out <= 1'b0;
      busy_out <= 1'b0;
      io_rdata_out <= `BYTE_ZERO;
    end else if (clk_en_in) begin
      if (rd_go) begin
        stall_q <= `READ_STALL - 3'h1; // RULE_03
        cpu_stall_out <= 1'b1;
      end else if (trig) begin
        stall_q <= `PROG_STALL - 3'h1; // RULE_04
        cpu_stall_out <= 1'b1;
      end else if (stall_q != 3'h0) begin
        stall_q <= stall_q - 3'h1;
      end else begin
        cpu_stall_out <= 1'b0;
      end
      busy_out <= busy_q;
      if (io_rd_in) begin
        case (io_addr_in)
          `IO_CTRL_ADDR: io_rdata_out <= ctrl_rd;
          `IO_DATA_ADDR: io_rdata_out <= data_q;
          `IO_ADR_ADDR: io_rdata_out <= {2'b00, adr_q}; // RULE_16
          default: io_rdata_out <= `BYTE_ZERO;
        endcase
      end
    end
  end

endmodule

//--- hw/storage_defines.vh
// constants for the byte storage access controller
`ifndef STORAGE_DEFINES_VH
`define STORAGE_DEFINES_VH
// io register addresses (6-bit io space)
`define IO_ADDR_W 6
`define IO_CTRL_ADDR 6'h1C
`define IO_DATA_ADDR 6'h1D
`define IO_ADR_ADDR 6'h1E
// control register bit positions
`define CTL_READ 0
`define CTL_TRIG 1
`define CTL_ARM 2
`define CTL_RDYIE 3
`define CTL_MODE_LO 4
`define CTL_MODE_HI 5
// program modes
`define MODE_ATOMIC 2'h0
`define MODE_ERASE 2'h1
`define MODE_WRITE 2'h2
`define MODE_RSVD 2'h3
// storage geometry
`define ADR_W 6
`define DEPTH 64
`define ERASED_BYTE 8'hFF
`define BYTE_ZERO 8'h00
// stall lengths and arm window in cpu cycles
`define READ_STALL 3'h4
`define PROG_STALL 3'h2
`define ARM_CYCLES 3'h4
// programming times in microseconds
`define T_ATOMIC_US 3400
`define T_SPLIT_US 1800
`endif

//--- testbench/storage_props.sv
// checker for the storage access controller
`timescale 1ns/1ns
module storage_props #(parameter [31:0] SPLIT_TICKS = 5) (
  // clock and reset
  input wire clock_in,
  input wire nrst_in,
  // io port and status
  input wire [5:0] io_addr_in,
  input wire io_rd_in,
  input wire [7:0] io_rdata_out,
  input wire cpu_stall_out,
  input wire busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  wire ctl = io_addr_in == 6'h1C;
  reg [2:0] st_q;
  reg [31:0] bc_q;
  ////////////////////////////////////////
  // run lengths; busy count survives a reset, as programming does
  always @(posedge clock_in) begin
    st_q <= cpu_stall_out ? st_q + 3'h1 : 3'h0;
    if (busy_out)
      bc_q <= bc_q + 32'h1;
    else if (nrst_in && $past(nrst_in))
      bc_q <= 32'h0;
  end
  ////////////////////////////////////////
  read_stall_a:
    assert property ($rose(cpu_stall_out) && !busy_out ##1 !busy_out
      |-> cpu_stall_out[*3] ##1 !cpu_stall_out) else $error("read stall length");
  prog_stall_a:
    assert property ($rose(busy_out) && $past(nrst_in, 3) |-> cpu_stall_out ##1 !cpu_stall_out)
    else $error("program stall length");
  stall_max_a:
    assert property (cpu_stall_out |-> st_q < 3'h4) else $error("stall too long");
  busy_min_a:
    assert property ($fell(busy_out) |-> $past(bc_q) >= SPLIT_TICKS) else $error("busy too short");
  adr_res_a:
    assert property (io_rd_in && io_addr_in == 6'h1E |=> io_rdata_out[7:6] == 2'h0)
    else $error("address reserved bits");
  ctl_res_a:
    assert property (io_rd_in && ctl |=> io_rdata_out[7:6] == 2'h0 && !io_rdata_out[0])
    else $error("control reserved bits");
  busy_bit_a:
    assert property (io_rd_in && ctl |=> io_rdata_out[1] == busy_out) else $error("busy bit");
  busy_block_a:
    assert property (busy_out && $past(busy_out, 3) |-> !$rose(cpu_stall_out))
    else $error("access while busy");
  cover property ($rose(busy_out));
  cover property ($fell(busy_out));
  cover property ($rose(cpu_stall_out) && !busy_out);
endmodule
////////////////////////////////////////
bind storage_access storage_props #(.SPLIT_TICKS(SPLIT_TICKS)) props_u (
  .clock_in(clock_in),
  .nrst_in(nrst_in),
  .io_addr_in(io_addr_in),
  .io_rd_in(io_rd_in),
  .io_rdata_out(io_rdata_out),
  .cpu_stall_out(cpu_stall_out),
  .busy_out(busy_out)
);

//--- testbench/osc_tick_model.sv
// free running calibrated oscillator for programming time
`timescale 1ns/1ns
module osc_tick_model (
  // oscillator output
  output reg tick_out
);
  // period unrelated to the cpu clock, so the synchroniser sees drifting phase
  initial begin
    tick_out = 1'h0;
    forever #170 tick_out = ~tick_out;
  end
endmodule

//--- testbench/tb_storage_access.sv
// self-checking bench for the storage access controller
`timescale 1ns/1ns
module tb_storage_access;
  reg clock_in = 1'h0, nrst_in = 1'h0, clk_en_in = 1'h1, io_wr_in = 1'h0, io_rd_in = 1'h0;
  reg io_bit_op_in = 1'h0, io_bit_val_in = 1'h0, rd_q = 1'h0;
  reg [5:0] io_addr_in = 6'h00, a;
  reg [7:0] io_wdata_in = 8'h00, d, ex;
  reg [2:0] io_bit_sel_in = 3'h0;
  reg [7:0] exp_q[$];
  wire [7:0] io_rdata_out;
  wire cpu_stall_out, busy_out, osc_tick_in;
  integer miscompares = 0, check_count = 0, i;
  initial forever #50 clock_in = ~clock_in;
  osc_tick_model osc_u (.tick_out(osc_tick_in));
  storage_access #(.ATOMIC_TICKS(8), .SPLIT_TICKS(5)) dut_u (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .clk_en_in(clk_en_in),
    .osc_tick_in(osc_tick_in),
    .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in),
    .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in),
    .io_bit_op_in(io_bit_op_in),
    .io_bit_sel_in(io_bit_sel_in),
    .io_bit_val_in(io_bit_val_in),
    .io_rdata_out(io_rdata_out),
    .cpu_stall_out(cpu_stall_out),
    .busy_out(busy_out)
  );
  ////////////////////////////////////////
  // one io access; s is bit-op flag and bit index, r marks a read expecting dt
  task io(input [5:0] ad, input [7:0] dt, input [3:0] s, input r);
    @(posedge clock_in);
    io_addr_in <= ad;
    io_wdata_in <= dt;
    {io_bit_op_in, io_bit_sel_in} <= s;
    io_bit_val_in <= dt[0];
    io_wr_in <= !r;
    io_rd_in <= r;
    if (r)
      exp_q.push_back(dt);
    @(posedge clock_in);
    io_wr_in <= 1'h0;
    io_rd_in <= 1'h0;
  endtask
  task rb(input [5:0] ad, input [7:0] dt);
    io(6'h1E, {2'h0, ad}, 4'h0, 1'h0);
    io(6'h1C, 8'h01, 4'h8, 1'h0);
    io(6'h1D, dt, 4'h0, 1'h1);
  endtask
  // mode, address, data, arm, then trigger two cycles later
  task pg(input [1:0] m, input [5:0] ad, input [7:0] dt);
    io(6'h1C, {2'h0, m, 4'h0}, 4'h0, 1'h0);
    io(6'h1E, {2'h0, ad}, 4'h0, 1'h0);
    io(6'h1D, dt, 4'h0, 1'h0);
    io(6'h1C, 8'h01, 4'hA, 1'h0);
    io(6'h1C, 8'h01, 4'h9, 1'h0);
  endtask
  task idle;
    repeat (3) @(posedge clock_in);
    for (i = 0; i < 300 && busy_out !== 1'h0; i = i + 1)
      @(posedge clock_in);
    if (i == 300) begin
      $display("BAD busy_out exp 0 seen %b", busy_out);
      miscompares = miscompares + 1;
      report_and_stop;
    end
  endtask
  task report_and_stop;
    if (exp_q.size() != 0) begin
      $display("BAD pending_reads exp 0 seen %0d", exp_q.size());
      miscompares = miscompares + 1;
    end
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // read data is registered, so the oldest note is compared a cycle later
  always @(posedge clock_in) rd_q <= io_rd_in;
  always @(negedge clock_in) begin
    if (rd_q) begin
      ex = exp_q.pop_front();
      check_count = check_count + 1;
      if (io_rdata_out !== ex) begin
        $display("BAD io_rdata_out exp %h seen %h", ex, io_rdata_out);
        miscompares = miscompares + 1;
      end
    end
  end
  ////////////////////////////////////////
  initial begin
    d = $urandom(32'h200B574C);
    a = $urandom % 64;
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'h1;
    pg(2'h0, a, d);
    idle;
    rb(a, d);
    pg(2'h1, a, d);
    idle;
    rb(a, 8'hFF);
    pg(2'h2, a, d);
    idle;
    rb(a, d);
    pg(2'h3, a, ~d);
    idle;
    io(6'h1C, 8'h30, 4'h0, 1'h1);
    rb(a, d);
    // reset while idle must clear the reserved mode left behind
    @(posedge clock_in);
    nrst_in <= 1'h0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'h1;
    io(6'h1C, 8'h00, 4'h0, 1'h1);
    io(6'h1C, 8'h00, 4'h0, 1'h0);
    io(6'h1C, 8'h01, 4'h9, 1'h0);
    io(6'h1C, 8'h00, 4'h0, 1'h1);
    pg(2'h0, a ^ 6'h01, ~d);
    repeat (3) @(posedge clock_in);
    io(6'h1E, 8'hFF, 4'h0, 1'h0);
    io(6'h1C, 8'h01, 4'h8, 1'h0);
    io(6'h1E, {2'h0, a ^ 6'h01}, 4'h0, 1'h1);
    io(6'h1C, 8'h02, 4'h0, 1'h1);
    // let the read be compared before reset clears the read data
    @(posedge clock_in);
    nrst_in <= 1'h0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'h1;
    io(6'h1C, 8'h02, 4'h0, 1'h1);
    idle;
    io(6'h1C, 8'h00, 4'h0, 1'h1);
    rb(a ^ 6'h01, ~d);
    rb(a, d);
    io(6'h1C, 8'h20, 4'h0, 1'h0);
    io(6'h1C, 8'h01, 4'hB, 1'h0);
    io(6'h1C, 8'h28, 4'h0, 1'h1);
    io(6'h1E, 8'hFF, 4'h0, 1'h0);
    io(6'h1E, 8'h3F, 4'h0, 1'h1);
    // the last read is compared on the next falling edge
    repeat (2) @(posedge clock_in);
    report_and_stop;
  end
endmodule
